// ---- pic_pkg.sv ----
// Shared constants and types for the position input block.
package pic_pkg;
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam int unsigned CYC_PER_US     = CLK_MHZ;
    localparam logic [7:0]  CYC_PER_US_M1  = 8'(CYC_PER_US - 1);
    localparam logic [2:0]  NS_PER_CYC     = 3'(CLK_PERIOD_NS);

    // Word-aligned byte offsets on the register bus
    localparam logic [5:0] REG_CTRL     = 6'h00;
    localparam logic [5:0] REG_SCALE    = 6'h04;
    localparam logic [5:0] REG_TURNS    = 6'h08;
    localparam logic [5:0] REG_RES_OFS  = 6'h0C;
    localparam logic [5:0] REG_RES_PRE  = 6'h10;
    localparam logic [5:0] REG_WIRE     = 6'h14;
    localparam logic [5:0] REG_FAULT_T  = 6'h18;
    localparam logic [5:0] REG_LDT_OFS  = 6'h1C;
    localparam logic [5:0] REG_LDT_PRE  = 6'h20;
    localparam logic [5:0] REG_POS      = 6'h24;
    localparam logic [5:0] REG_STATUS   = 6'h28;

    // Control register fields
    localparam int CTL_PROG   = 0;
    localparam int CTL_WRAP   = 1;
    localparam int CTL_RPM    = 2;
    localparam int CTL_DIR    = 3;
    localparam int CTL_MM     = 4;
    localparam int CTL_KIND_L = 5;
    localparam int CTL_KIND_H = 6;
    localparam int CTL_CARD   = 7;
    localparam int CTL_SRC    = 8;
    localparam int CTL_W      = 9;
    // Direction defaults to 1, all else 0
    localparam logic [CTL_W-1:0] CTL_RESET = 9'h008;

    // Status register fields
    localparam int ST_FAULT  = 0;
    localparam int ST_REFUSE = 1;

    // Output kinds of the transducer
    localparam logic [1:0] KIND_ZERO  = 2'h0;
    localparam logic [1:0] KIND_ONE   = 2'h1;
    localparam logic [1:0] KIND_VP_EXT = 2'h2;
    localparam logic [1:0] KIND_VP_INT = 2'h3;

    // Reset values
    localparam logic [31:0] SCALE_RESET = 32'h0000_1000;
    localparam logic [31:0] TURNS_RESET = 32'h0000_0000;
    localparam logic [31:0] WIRE_RESET  = 32'h0007_A120;
    localparam logic [6:0]  FAULT_RESET = 7'h0A;

    // Accepted ranges; wire speed in 0.001 us/inch, offsets in 0.001 units
    localparam logic [31:0] WIRE_VP_MIN  = 32'h0007_A120;
    localparam logic [31:0] WIRE_VP_MAX  = 32'h0009_27C0;
    localparam logic [31:0] WIRE_GD_MIN  = 32'h0000_1F40;
    localparam logic [31:0] WIRE_GD_MAX  = 32'h0000_2710;
    localparam logic [31:0] FAULT_MAX    = 32'h0000_0063;
    localparam logic signed [31:0] OFS_MIN = 32'shFFFE_7961;
    localparam logic signed [31:0] OFS_MAX = 32'sh000F_423F;

    // Time to scaled position: inch gives 0.001 in, mm gives 0.01 mm
    localparam logic [11:0] UNIT_MUL_IN = 12'h3E8;
    localparam logic [11:0] UNIT_MUL_MM = 12'h9EC;

    localparam int MEAS_W = 20;
    localparam int DIV_NW = 40;
    localparam int DIV_DW = 20;
    localparam logic [MEAS_W-1:0] MEAS_MAX = 20'hFFFFF;

    localparam int unsigned INTERROG_US_DEF = 1000;

    typedef enum logic {
        PIC_IDLE = 1'b0,
        PIC_MEAS = 1'b1
    } pic_meas_t;
endpackage

// ---- pic_divider.sv ----
// Serial restoring divider used to turn echo time into position.
`timescale 1ns/1ps
module pic_divider
    import pic_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              start,
    input  wire logic [DIV_NW-1:0] dividend,
    input  wire logic [DIV_DW-1:0] divisor,
    output logic                   busy,
    output logic                   done,
    output logic [DIV_NW-1:0]      quotient
);
    logic [DIV_NW-1:0] quo_q;
    logic [DIV_DW:0]   rem_q;
    logic [5:0]        cnt_q;
    logic              busy_q;
    logic              done_q;
    wire  [DIV_DW:0]   shifted = {rem_q[DIV_DW-1:0], quo_q[DIV_NW-1]};
    wire  [DIV_DW:0]   diff    = shifted - {1'b0, divisor};
    wire               fits    = ~diff[DIV_DW];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            quo_q  <= '0;
            rem_q  <= '0;
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                quo_q  <= dividend;
                rem_q  <= '0;
                cnt_q  <= 6'(DIV_NW);
                busy_q <= 1'b1;
            end else if (busy_q) begin
                quo_q  <= {quo_q[DIV_NW-2:0], fits};
                rem_q  <= fits ? diff : shifted;
                cnt_q  <= cnt_q - 6'h01;
                busy_q <= (cnt_q != 6'h01);
                done_q <= (cnt_q == 6'h01);
            end
        end
    end

    assign busy     = busy_q;
    assign done     = done_q;
    assign quotient = quo_q;
endmodule

// ---- pic_top.sv ----
// Position input block: resolver counting and transducer timing to position.
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module pic_top
    import pic_pkg::*;
#(
    parameter int unsigned INTERROG_US = INTERROG_US_DEF
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        res_step,
    input  wire logic        res_up,
    input  wire logic        res_preset_in,
    input  wire logic        ldt_return,
    input  wire logic        ldt_preset_in,
    output logic             ldt_interrogate,
    output logic [31:0]      position,
    output logic             show_rpm,
    output logic             fault_flag
);
    localparam int unsigned INTERROG_CYC = INTERROG_US * CYC_PER_US;

    function automatic logic [31:0] sel_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic rise(input logic now_v, input logic prev_v);
        return now_v & ~prev_v;
    endfunction

    logic [CTL_W-1:0] ctl_q;
    logic [31:0]      scale_q;
    logic [31:0]      turns_q;
    logic [31:0]      res_ofs_q;
    logic [31:0]      res_pre_q;
    logic [31:0]      wire_q;
    logic [6:0]       fault_t_q;
    logic [31:0]      ldt_ofs_q;
    logic [31:0]      ldt_pre_q;
    logic [31:0]      res_cnt_q;
    logic [31:0]      ldt_scaled_q;
    logic [31:0]      pos_q;
    logic             fault_q;
    logic             refuse_q;
    logic             ack_q;
    logic [31:0]      rdat_q;
    logic             res_pre_prev_q;
    logic             ldt_pre_prev_q;
    logic             ret_prev_q;
    logic [31:0]      itg_cnt_q;
    pic_meas_t        meas_q;
    logic [MEAS_W-1:0] meas_cnt_q;
    logic [7:0]       presc_q;
    logic [6:0]       us_cnt_q;
    logic             div_start_q;
    logic [DIV_NW-1:0] div_num_q;
    logic             div_done;
    logic [DIV_NW-1:0] div_quo;
    logic [31:0]      rd_mux;

    // Bus decode
    wire        bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
    wire        bus_wr    = bus_req & wb_we_i;
    wire        prog_mode = ctl_q[CTL_PROG];
    wire [31:0] wval      = sel_merge(32'h0, wb_dat_i, wb_sel_i);
    wire        cfg_wr    = bus_wr & (wb_adr_i != REG_CTRL) & (wb_adr_i != REG_STATUS);
    wire        cfg_ok    = cfg_wr & prog_mode;

    wire [1:0]  kind      = ctl_q[CTL_KIND_H:CTL_KIND_L];
    wire        wire_in_range = ctl_q[CTL_CARD]
                            ? (wval >= WIRE_GD_MIN && wval <= WIRE_GD_MAX)
                            : (wval >= WIRE_VP_MIN && wval <= WIRE_VP_MAX);
    wire        fault_in_range = (wval <= FAULT_MAX);
    wire        ofs_in_range   = ($signed(wval) >= OFS_MIN) && ($signed(wval) <= OFS_MAX);

    wire        wr_ctl    = bus_wr & (wb_adr_i == REG_CTRL);
    wire        wr_scale  = cfg_ok & (wb_adr_i == REG_SCALE);
    wire        wr_turns  = cfg_ok & (wb_adr_i == REG_TURNS);
    wire        wr_res_ofs = cfg_ok & (wb_adr_i == REG_RES_OFS);
    wire        wr_res_pre = cfg_ok & (wb_adr_i == REG_RES_PRE);
    wire        wr_wire   = cfg_ok & (wb_adr_i == REG_WIRE) & wire_in_range;
    wire        wr_fault_t = cfg_ok & (wb_adr_i == REG_FAULT_T) & fault_in_range;
    wire        wr_ldt_ofs = cfg_ok & (wb_adr_i == REG_LDT_OFS) & ofs_in_range;
    wire        wr_ldt_pre = cfg_ok & (wb_adr_i == REG_LDT_PRE);
    wire        wr_status = bus_wr & (wb_adr_i == REG_STATUS);
    wire        bad_value = cfg_ok & (((wb_adr_i == REG_WIRE) & ~wire_in_range)
                          | ((wb_adr_i == REG_FAULT_T) & ~fault_in_range)
                          | ((wb_adr_i == REG_LDT_OFS) & ~ofs_in_range));
    wire        refuse_ev = (cfg_wr & ~prog_mode) | bad_value;

    // Control bits other than program mode change only in program mode
    wire [CTL_W-1:0] ctl_wval = prog_mode ? wval[CTL_W-1:0]
                              : {ctl_q[CTL_W-1:1], wval[CTL_PROG]};

    // Resolver counting
    wire        res_pre_edge = rise(res_preset_in, res_pre_prev_q);
    wire        wrap_on  = ctl_q[CTL_WRAP];
    wire        at_top   = (res_cnt_q == scale_q - 32'h1);
    wire        at_zero  = (res_cnt_q == 32'h0);
    wire [31:0] res_step_v = !res_up ? ((wrap_on && at_zero) ? scale_q - 32'h1
                                                             : res_cnt_q - 32'h1)
                           : ((wrap_on && at_top) ? 32'h0 : res_cnt_q + 32'h1);

    // Transducer timing and echo measurement
    wire        ldt_pre_edge = rise(ldt_preset_in, ldt_pre_prev_q);
    wire        ret_rise = rise(ldt_return, ret_prev_q);
    wire        ret_fall = ~ldt_return & ret_prev_q;
    wire        itg_fire = (itg_cnt_q == 32'h0);
    wire        vp_kind  = (kind == KIND_VP_EXT) | (kind == KIND_VP_INT);
    wire        drives_itg = (kind != KIND_VP_EXT);
    wire        meas_start = vp_kind ? ret_rise : itg_fire;
    wire        meas_end   = vp_kind ? ret_fall : ret_rise;
    wire        fault_hit  = (fault_t_q != 7'h0) && (us_cnt_q == fault_t_q);
    wire [11:0] unit_mul   = ctl_q[CTL_MM] ? UNIT_MUL_MM : UNIT_MUL_IN;
    wire [DIV_NW-1:0] echo_ns = DIV_NW'(meas_cnt_q) * DIV_NW'(NS_PER_CYC);
    wire [DIV_NW-1:0] num_v   = DIV_NW'(echo_ns * DIV_NW'(unit_mul));
    wire [31:0] ldt_dir_v = ctl_q[CTL_DIR] ? 32'h0 - ldt_scaled_q : ldt_scaled_q;
    wire [31:0] pos_d = ctl_q[CTL_SRC] ? ldt_dir_v + ldt_ofs_q
                                       : res_cnt_q + res_ofs_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_q     <= CTL_RESET;
            scale_q   <= SCALE_RESET;
            turns_q   <= TURNS_RESET;
            res_pre_q <= '0;
            wire_q    <= WIRE_RESET;
            fault_t_q <= FAULT_RESET;
            ldt_pre_q <= '0;
        end else begin
            if (wr_ctl) ctl_q <= ctl_wval;
            if (wr_scale) scale_q <= wval;
            if (wr_turns) turns_q <= wval;
            if (wr_res_pre) res_pre_q <= wval;
            if (wr_wire) wire_q <= wval;
            if (wr_fault_t) fault_t_q <= wval[6:0];
            if (wr_ldt_pre) ldt_pre_q <= wval;
        end
    end

    // Resolver count and offsets; the resolver preset rewrites the count, the transducer preset rewrites the offset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_cnt_q <= '0;
            res_ofs_q <= '0;
            ldt_ofs_q <= '0;
        end else begin
            if (res_pre_edge) begin
                res_cnt_q <= res_pre_q - res_ofs_q;
            end else if (res_step) begin
                res_cnt_q <= res_step_v;
            end
            if (wr_res_ofs) res_ofs_q <= wval - res_cnt_q;
            if (ldt_pre_edge) begin
                ldt_ofs_q <= ldt_pre_q - ldt_dir_v;
            end else if (wr_ldt_ofs) begin
                ldt_ofs_q <= wval - ldt_dir_v;
            end
        end
    end

    // Echo measurement: interval or pulse width by output kind
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meas_q      <= PIC_IDLE;
            meas_cnt_q  <= '0;
            presc_q     <= '0;
            us_cnt_q    <= '0;
            itg_cnt_q   <= '0;
            div_start_q <= 1'b0;
            div_num_q   <= '0;
        end else begin
            div_start_q <= 1'b0;
            itg_cnt_q   <= itg_fire ? 32'(INTERROG_CYC - 1) : itg_cnt_q - 32'h1;
            unique case (meas_q)
                PIC_IDLE: begin
                    if (meas_start) begin
                        meas_q     <= PIC_MEAS;
                        meas_cnt_q <= '0;
                        presc_q    <= '0;
                        us_cnt_q   <= '0;
                    end
                end
                PIC_MEAS: begin
                    if (meas_end) begin
                        meas_q <= PIC_IDLE;
                        if (!fault_hit) begin
                            div_start_q <= 1'b1;
                            div_num_q   <= num_v;
                        end
                    end else begin
                        if (meas_cnt_q != MEAS_MAX) meas_cnt_q <= meas_cnt_q + 1'b1;
                        if (presc_q == CYC_PER_US_M1) begin
                            presc_q <= '0;
                            if (us_cnt_q != 7'h7F) us_cnt_q <= us_cnt_q + 7'h01;
                        end else begin
                            presc_q <= presc_q + 8'h01;
                        end
                    end
                end
            endcase
        end
    end

    // Status, edge history, position and bus answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_q        <= 1'b0;
            refuse_q       <= 1'b0;
            res_pre_prev_q <= 1'b0;
            ldt_pre_prev_q <= 1'b0;
            ret_prev_q     <= 1'b0;
            ldt_scaled_q   <= '0;
            pos_q          <= '0;
            ack_q          <= 1'b0;
            rdat_q         <= '0;
        end else begin
            // A new event wins over a write-one clear in the same cycle
            fault_q  <= (meas_q == PIC_MEAS && meas_end && fault_hit)
                      | (fault_q & ~(wr_status & wval[ST_FAULT]));
            refuse_q <= refuse_ev | (refuse_q & ~(wr_status & wval[ST_REFUSE]));
            res_pre_prev_q <= res_preset_in;
            ldt_pre_prev_q <= ldt_preset_in;
            ret_prev_q     <= ldt_return;
            if (div_done) ldt_scaled_q <= div_quo[31:0];
            pos_q  <= pos_d;
            ack_q  <= bus_req;
            if (bus_req && !wb_we_i) rdat_q <= rd_mux;
        end
    end

    always_comb begin
        unique case (wb_adr_i)
            REG_CTRL:    rd_mux = 32'(ctl_q);
            REG_SCALE:   rd_mux = scale_q;
            REG_TURNS:   rd_mux = turns_q;
            REG_RES_OFS: rd_mux = res_ofs_q;
            REG_RES_PRE: rd_mux = res_pre_q;
            REG_WIRE:    rd_mux = wire_q;
            REG_FAULT_T: rd_mux = 32'(fault_t_q);
            REG_LDT_OFS: rd_mux = ldt_ofs_q;
            REG_LDT_PRE: rd_mux = ldt_pre_q;
            REG_POS:     rd_mux = pos_q;
            REG_STATUS:  rd_mux = {30'h0, refuse_q, fault_q};
            default:     rd_mux = 32'h0;
        endcase
    end

    // Divisor is wire speed; it stays within 20 bits across both ranges
    pic_divider u_div (
        .clk      (clk),
        .rst      (rst),
        .start    (div_start_q),
        .dividend (div_num_q),
        .divisor  (wire_q[DIV_DW-1:0]),
        .busy     (),
        .done     (div_done),
        .quotient (div_quo)
    );

    assign wb_ack_o        = ack_q;
    assign wb_dat_o        = rdat_q;
    assign position        = pos_q;
    assign show_rpm        = ctl_q[CTL_RPM];
    assign fault_flag      = fault_q;
    assign ldt_interrogate = drives_itg & itg_fire;
endmodule

// ---- pic_top_props.sv ----
// Port-level checks on the position input block.
`timescale 1ns/1ps
module pic_top_props
    import pic_pkg::*;
#(
    parameter int unsigned INTERROG_US = INTERROG_US_DEF
)(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        res_step,
    input wire logic        res_up,
    input wire logic        res_preset_in,
    input wire logic        ldt_return,
    input wire logic        ldt_preset_in,
    input wire logic        ldt_interrogate,
    input wire logic [31:0] position,
    input wire logic        show_rpm,
    input wire logic        fault_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    wire req_w    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire ctl_wr_w = wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == REG_CTRL);
    wire clr_w    = wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == REG_STATUS)
                    && wb_sel_i[0] && wb_dat_i[ST_FAULT];
    wire pos_rd_w = req_w && !wb_we_i && (wb_adr_i == REG_POS);
    wire gap_rd_w = req_w && !wb_we_i && (wb_adr_i > REG_STATUS);

    sequence ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence itg_quiet;
        !ldt_interrogate [*8];
    endsequence

    a_ack_follows: assert property (req_w |=> ack_pulse)
        else $error("request not answered by a single ack");
    a_ack_cause: assert property (wb_ack_o |-> $past(req_w))
        else $error("ack without a request");
    a_unmapped_zero: assert property (gap_rd_w |=> wb_dat_o == 32'h0)
        else $error("unmapped read returned data");
    a_pos_readback: assert property (pos_rd_w |=> wb_dat_o == $past(position))
        else $error("position read differs from position port");
    a_rpm_stable: assert property (!ctl_wr_w |=> $stable(show_rpm))
        else $error("display choice moved without a control write");
    a_fault_sticky: assert property (fault_flag && !clr_w |=> fault_flag)
        else $error("fault flag dropped without a clear");
    a_itg_pulse: assert property (ldt_interrogate |=> itg_quiet)
        else $error("interrogate pulse too long or too close");
    a_step_quiet: assert property (res_step |-> !wb_ack_o || wb_cyc_i)
        else $error("ack seen with bus idle during a step");
endmodule

bind pic_top pic_top_props #(.INTERROG_US(INTERROG_US)) u_props (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .res_step(res_step), .res_up(res_up),
    .res_preset_in(res_preset_in), .ldt_return(ldt_return), .ldt_preset_in(ldt_preset_in),
    .ldt_interrogate(ldt_interrogate), .position(position), .show_rpm(show_rpm),
    .fault_flag(fault_flag)
);

// ---- pic_sensor.sv ----
// Behavioural resolver and transducer on the far side of the block.
`timescale 1ns/1ps
module pic_sensor (
    input  wire logic clk,
    output logic      res_step,
    output logic      res_up,
    output logic      ldt_return
);
    initial begin
        res_step   = 1'b0;
        res_up     = 1'b1;
        ldt_return = 1'b0;
    end

    // Steps stay one cycle apart so each is seen as its own count
    task automatic steps(input int n, input logic up);
        repeat (n) begin
            @(posedge clk);
            res_step <= 1'b1;
            res_up   <= up;
            @(posedge clk);
            res_step <= 1'b0;
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic pulse(input int w);
        @(posedge clk);
        ldt_return <= 1'b1;
        repeat (w) @(posedge clk);
        ldt_return <= 1'b0;
    endtask
endmodule

// ---- position_input_config_bench.sv ----
// Self-checking bench for the position input block.
`timescale 1ns/1ps
module position_input_config_bench;
    import pic_pkg::*;
    logic        clk;
    logic        rst  = 1'b1;
    logic        cyc  = 1'b0;
    logic        stb  = 1'b0;
    logic        we   = 1'b0;
    logic        rpi  = 1'b0;
    logic        lpi  = 1'b0;
    logic [5:0]  adr  = 6'h00;
    logic [3:0]  sel  = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rnd;
    logic [31:0] rdat;
    logic [31:0] pos;
    logic        ack, itg, rpm, flt, step, up, ret;
    int          n_mismatch = 0;
    int          n_tests    = 0;
    int          n_itg      = 0;
    logic [31:0] expq[$];

    pic_sensor u_sen (.clk(clk), .res_step(step), .res_up(up), .ldt_return(ret));

    // Short interrogate period keeps the kind sweep brief
    pic_top #(.INTERROG_US(4)) dut (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .res_step(step), .res_up(up), .res_preset_in(rpi), .ldt_return(ret),
        .ldt_preset_in(lpi), .ldt_interrogate(itg), .position(pos), .show_rpm(rpm),
        .fault_flag(flt)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Holds the request until the edge that samples ack high; only the watchdog ends a hang
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [31:0] e);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        if (!w) expq.push_back(e);
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF, 32'h0);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF, e);
    endtask

    task automatic fault_try(input int w, input logic [31:0] e);
        u_sen.pulse(w);
        repeat (60) @(posedge clk);
        rd(REG_STATUS, e);
    endtask

    // Read data is taken at the same edge as the master sees ack
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) chk(rdat, expq.pop_front());
        if (itg === 1'b1) n_itg++;
    end

    initial begin
        rnd = 32'h3833C039;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(REG_CTRL, 32'h0000_0008);
        rd(REG_SCALE, SCALE_RESET);
        rd(REG_WIRE, WIRE_RESET);
        rd(REG_FAULT_T, 32'h0000_000A);
        $display("test reset values done");
        wr(REG_SCALE, 32'h4);
        rd(REG_SCALE, SCALE_RESET);
        rd(REG_STATUS, 32'h2);
        wr(REG_STATUS, 32'h3);
        wr(REG_CTRL, 32'h0000_000B);
        rd(REG_CTRL, 32'h0000_0009);
        wr(REG_CTRL, 32'h0000_000B);
        rd(REG_CTRL, 32'h0000_000B);
        rd(6'h3C, 32'h0);
        rnd = lfsr(rnd);
        bus(1'b1, REG_RES_PRE, rnd, 4'h3, 32'h0);
        rd(REG_RES_PRE, {16'h0, rnd[15:0]});
        $display("test program mode done");
        wr(REG_SCALE, 32'h4);
        u_sen.steps(5, 1'b1);
        rd(REG_POS, 32'h1);
        u_sen.steps(2, 1'b0);
        rd(REG_POS, 32'h3);
        wr(REG_CTRL, 32'h0000_0009);
        wr(REG_RES_OFS, 32'h64);
        rd(REG_POS, 32'h64);
        wr(REG_RES_PRE, 32'h2);
        rpi <= 1'b1;
        repeat (3) @(posedge clk);
        rd(REG_POS, 32'h2);
        u_sen.steps(1, 1'b1);
        rd(REG_POS, 32'h3);
        rpi <= 1'b0;
        $display("test resolver done");
        wr(REG_CTRL, 32'h0000_000D);
        @(negedge clk);
        chk({31'h0, rpm}, 32'h1);
        wr(REG_CTRL, 32'h0000_0009);
        wr(REG_WIRE, 32'h0007_A11F);
        rd(REG_WIRE, WIRE_RESET);
        wr(REG_WIRE, WIRE_VP_MAX);
        rd(REG_WIRE, WIRE_VP_MAX);
        wr(REG_CTRL, 32'h0000_0089);
        wr(REG_WIRE, 32'h0000_2711);
        rd(REG_WIRE, WIRE_VP_MAX);
        wr(REG_WIRE, WIRE_GD_MIN);
        rd(REG_WIRE, WIRE_GD_MIN);
        $display("test setup values done");
        for (int k = 0; k < 4; k++) begin
            wr(REG_CTRL, 32'h0000_0189 | 32'(k << 5));
            n_itg = 0;
            repeat (1100) @(posedge clk);
            chk({31'h0, n_itg > 0}, {31'h0, k != 2});
        end
        $display("test output kinds done");
        wr(REG_CTRL, 32'h0000_01C9);
        // Ends the measurement that the interval kinds left open with no echo
        u_sen.pulse(4);
        repeat (60) @(posedge clk);
        wr(REG_STATUS, 32'h3);
        fault_try(800, 32'h0);
        fault_try(2625, 32'h1);
        wr(REG_STATUS, 32'h1);
        wr(REG_FAULT_T, 32'h0);
        fault_try(2625, 32'h0);
        wr(REG_FAULT_T, 32'h64);
        rd(REG_FAULT_T, 32'h0);
        wr(REG_FAULT_T, 32'h5);
        wr(REG_STATUS, 32'h3);
        fault_try(1400, 32'h1);
        $display("test fault pulse done");
        wr(REG_LDT_OFS, 32'h3E8);
        rd(REG_POS, 32'h3E8);
        wr(REG_LDT_OFS, 32'h000F_4240);
        rd(REG_POS, 32'h3E8);
        wr(REG_LDT_PRE, 32'h1234);
        lpi <= 1'b1;
        repeat (3) @(posedge clk);
        rd(REG_POS, 32'h1234);
        lpi <= 1'b0;
        // Width 1001 gives 1000 counted cycles, 4 us: 500 in inches, 1270 in mm
        u_sen.pulse(1001);
        repeat (60) @(posedge clk);
        rd(REG_POS, 32'h0000_1560);
        wr(REG_CTRL, 32'h0000_01D1);
        u_sen.pulse(1001);
        repeat (60) @(posedge clk);
        rd(REG_POS, 32'h0000_1C4A);
        $display("test transducer preset done");
        results();
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        $display("watchdog expired");
        results();
    end
endmodule
